// *** include/lcr_regs.svh ***
// Constants for the column-RAM access block: opcodes, fields, resets, timing.
// Assumes inclusion by bare name; holds definitions only.
`ifndef LCR_REGS_SVH
`define LCR_REGS_SVH
`define LCR_CONT_BIT 7
`define LCR_OP_XLOAD_BIT 6
`define LCR_OP_MODE 2'b10
`define LCR_OP_DEVSEL 3'b110
`define LCR_OP_BANK 5'b11111
`define LCR_LAST_COL 6'd39
`define LCR_LAST_BANK 2'd3
`define LCR_LAST_SUB 4'hf
`define LCR_ROWS8_LAST 5'd7
`define LCR_ROWS16_LAST 5'd15
`define LCR_ROWS24_LAST 5'd23
`define LCR_ROWS32_LAST 5'd31
`define LCR_RST_X 6'h00
`define LCR_RST_Y 2'h0
`define LCR_RST_SUB 4'h0
`define LCR_RST_BANK 2'h0
`define LCR_RST_MUX 2'h0
`define LCR_ROW_TIME_NS 100000
`define LCR_CLK_PERIOD_NS 100
`endif

// *** include/lcr_pkg.sv ***
// Types shared by the column-RAM access block.
// Assumes lcr_regs.svh is available on the include path.
package lcr_pkg;
  typedef enum logic [1:0] {
    LCR_ACC_CHAR = 2'b00,
    LCR_ACC_HALF = 2'b01,
    LCR_ACC_FULL = 2'b10
  } lcr_acc_t;
  typedef enum logic [1:0] {
    LCR_DS_BLANK = 2'b00,
    LCR_DS_NORMAL = 2'b01,
    LCR_DS_ALLON = 2'b10,
    LCR_DS_INVERSE = 2'b11
  } lcr_dstat_t;
  typedef enum logic [0:0] {
    LCR_ST_CMD = 1'b0,
    LCR_ST_DATA = 1'b1
  } lcr_state_t;
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } lcr_byte_t;
endpackage

// *** verilog/lcr_column_ram_access.sv ***
// Command interpreter, display RAM and row scan of a cascadable LCD column driver,
// with its input byte FIFO. Assumes a bus front end on the same clock that delivers
// each written byte with a flag marking the first byte after the slave address.
`timescale 1ns/1ns
`default_nettype none
`include "lcr_regs.svh"

module lcr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r, cnt_nxt;
  logic full_r, empty_r;
  wire push = in_valid_i && !full_r;
  wire pop = out_ready_i && !empty_r;
  assign cnt_nxt = (push && !pop) ? cnt_r + 1'b1 : ((pop && !push) ? cnt_r - 1'b1 : cnt_r);
  assign in_ready_o = !full_r;
  assign out_valid_o = !empty_r;
  assign out_data_o = mem[rp_r];
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      wp_r <= push ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
      rp_r <= pop ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
      cnt_r <= cnt_nxt;
      full_r <= (cnt_nxt == FULL_CNT);
      empty_r <= (cnt_nxt == '0);
    end
  end
endmodule

// Notes on behaviour
// - Three access modes (character, half-graphic, full-graphic) chosen by the mode field set the byte order.
// - Each data byte after the first goes to the next location given by the access mode.
// - Running past the last column of one device advances the subaddress counter to the next device.
// - Past subaddress 15 the subaddress counter wraps to 0.
// - Rows of RAM are shifted to the column outputs continuously without host help.
// - The number of rows scanned per frame follows the two-bit multiplex field.
// - The display status field gives blank, normal, all-on or inverse output.
// - The start bank field picks the bank shown at the top row, for scrolling.
// - A command with top bit 0 is the last one; the next byte is display data.
// - Mode code 00 is character, 01 half-graphic, 10 full-graphic; 11 is the start-bank opcode.
// - The column pointer loads 0 to 63 but writes only at 0 to 39, and the row bank is one of four rows.
module lcr_column_ram_access
  import lcr_pkg::*;
#(
  parameter int NCOL = 40,
  parameter int FIFO_DEPTH = 8,
  parameter logic [3:0] LAST_SUB = `LCR_LAST_SUB
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Written bytes from the bus front end
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_first_i,
  output logic rx_ready_o,
  // Hardware subaddress pins
  input wire logic [3:0] hw_subaddr_i,
  // Display outputs
  output logic [NCOL-1:0] col_o,
  output logic [4:0] row_o,
  output logic frame_sync_o,
  output logic [1:0] disp_status_o,
  output logic [1:0] mux_sel_o
);
  localparam int ROW_CYC_I = `LCR_ROW_TIME_NS / `LCR_CLK_PERIOD_NS;
  localparam logic [15:0] ROW_CYC = 16'(ROW_CYC_I < 1 ? 1 : ROW_CYC_I);
  logic [7:0] mem [0:3][0:NCOL-1];
  lcr_state_t state_r;
  lcr_acc_t acc_r;
  lcr_dstat_t dstat_r;
  logic [5:0] x_r;
  logic [1:0] y_r, bank_r, mux_r;
  logic [3:0] sub_r, own_sub_r, sub_s1_r, sub_s2_r, sub_s3_r;
  logic [15:0] div_r;
  logic [4:0] row_r;
  logic fifo_in_ready, fifo_out_valid;
  lcr_byte_t fifo_in, fifo_out;
  // Scan tick steals the drain cycle so the RAM sees one user per cycle
  wire tick = (div_r == ROW_CYC - 16'd1);
  wire pop = fifo_out_valid && !tick;
  wire [7:0] b = fifo_out.data;
  wire is_cmd = fifo_out.first || (state_r == LCR_ST_CMD);
  wire pop_cmd = pop && is_cmd;
  wire pop_data = pop && !is_cmd;
  wire op_x = !b[`LCR_OP_XLOAD_BIT];
  wire op_mode = b[6:5] == `LCR_OP_MODE;
  wire op_dev = b[6:4] == `LCR_OP_DEVSEL;
  wire op_bank = b[6:2] == `LCR_OP_BANK;
  wire op_acc = !op_x && !op_mode && !op_dev && !op_bank;
  assign fifo_in = '{first: rx_first_i, data: rx_byte_i};
  lcr_fifo #(.WIDTH($bits(lcr_byte_t)), .DEPTH(FIFO_DEPTH)) lcr_fifo_i (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(rx_valid_i),
    .in_data_i(fifo_in),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out),
    .out_ready_i(pop)
  );
  // Auto-increment per access mode
  wire x_step = (acc_r == LCR_ACC_CHAR) ||
                (acc_r == LCR_ACC_HALF && y_r[0]) ||
                (acc_r == LCR_ACC_FULL && y_r == `LCR_LAST_BANK);
  wire [1:0] y_adv = (acc_r == LCR_ACC_HALF) ? {y_r[1], ~y_r[0]} :
                     (acc_r == LCR_ACC_FULL) ? y_r + 2'd1 : y_r;
  wire col_end = x_step && (x_r >= `LCR_LAST_COL);
  wire [5:0] x_adv = !x_step ? x_r : (col_end ? `LCR_RST_X : x_r + 6'd1);
  wire [3:0] sub_adv = !col_end ? sub_r :
                       ((sub_r == LAST_SUB) ? `LCR_RST_SUB : sub_r + 4'd1);
  wire wr_en = pop_data && (sub_r == own_sub_r) && (x_r <= `LCR_LAST_COL);

  always_ff @(posedge clock_i) begin
    if (wr_en) begin
      mem[y_r][x_r] <= b;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= LCR_ST_CMD;
    end else if (pop_cmd) begin
      state_r <= b[`LCR_CONT_BIT] ? LCR_ST_CMD : LCR_ST_DATA;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dstat_r <= LCR_DS_BLANK;
      mux_r <= `LCR_RST_MUX;
      bank_r <= `LCR_RST_BANK;
      acc_r <= LCR_ACC_CHAR;
    end else if (pop_cmd) begin
      if (op_mode) begin
        dstat_r <= lcr_dstat_t'(b[3:2]);
        mux_r <= b[1:0];
      end
      if (op_bank) begin
        bank_r <= b[1:0];
      end
      if (op_acc) begin
        acc_r <= lcr_acc_t'(b[3:2]);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      x_r <= `LCR_RST_X;
      y_r <= `LCR_RST_Y;
      sub_r <= `LCR_RST_SUB;
    end else if (pop_cmd) begin
      x_r <= op_x ? b[5:0] : x_r;
      y_r <= op_acc ? b[1:0] : y_r;
      sub_r <= op_dev ? b[3:0] : sub_r;
    end else if (pop_data) begin
      x_r <= x_adv;
      y_r <= y_adv;
      sub_r <= sub_adv;
    end
  end

  // Pin synchroniser; a new value counts once stages two and three agree
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sub_s1_r <= '0;
      sub_s2_r <= '0;
      sub_s3_r <= '0;
      own_sub_r <= '0;
    end else begin
      sub_s1_r <= hw_subaddr_i;
      sub_s2_r <= sub_s1_r;
      sub_s3_r <= sub_s2_r;
      own_sub_r <= (sub_s2_r == sub_s3_r) ? sub_s3_r : own_sub_r;
    end
  end

  // Row scan
  wire [4:0] row_last = (mux_r == 2'b01) ? `LCR_ROWS8_LAST :
                        (mux_r == 2'b10) ? `LCR_ROWS16_LAST :
                        (mux_r == 2'b11) ? `LCR_ROWS24_LAST : `LCR_ROWS32_LAST;
  wire row_wrap = (row_r >= row_last);
  wire [1:0] scan_bank = bank_r + row_r[4:3];
  wire [2:0] scan_bit = row_r[2:0];
  logic [NCOL-1:0] col_nxt;

  genvar c;
  generate
    for (c = 0; c < NCOL; c++) begin : g_col
      wire dot = mem[scan_bank][c][scan_bit];
      assign col_nxt[c] = (dstat_r == LCR_DS_NORMAL) ? dot :
                          (dstat_r == LCR_DS_ALLON) ? 1'b1 :
                          (dstat_r == LCR_DS_INVERSE) ? ~dot : 1'b0;
    end
  endgenerate

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= '0;
      row_r <= '0;
      col_o <= '0;
      row_o <= '0;
      frame_sync_o <= 1'b0;
    end else begin
      div_r <= tick ? '0 : div_r + 16'd1;
      frame_sync_o <= tick && row_wrap;
      if (tick) begin
        row_r <= row_wrap ? 5'd0 : row_r + 5'd1;
        col_o <= col_nxt;
        row_o <= row_r;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_ready_o <= 1'b0;
      disp_status_o <= LCR_DS_BLANK;
      mux_sel_o <= `LCR_RST_MUX;
    end else begin
      rx_ready_o <= fifo_in_ready && !(rx_valid_i && fifo_in_ready);
      disp_status_o <= dstat_r;
      mux_sel_o <= mux_r;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_data_pop;
    pop_data && !col_end;
  endsequence
  sequence s_col_end_pop;
    pop_data && col_end;
  endsequence

  AST_CHAR_STEP: assert property (
    s_data_pop ##0 (acc_r == LCR_ACC_CHAR) |=> (x_r == $past(x_r) + 6'd1) && (y_r == $past(y_r)))
    else $error("character mode did not step the column");
  AST_HALF_STEP: assert property (
    s_data_pop ##0 (acc_r == LCR_ACC_HALF) |=> y_r[0] != $past(y_r[0]))
    else $error("half-graphic mode did not alternate the row");
  AST_SUB_INC: assert property (
    s_col_end_pop ##0 (sub_r != LAST_SUB) |=> (sub_r == $past(sub_r) + 4'd1) && (x_r == 6'd0))
    else $error("subaddress did not advance at column end");
  AST_SUB_WRAP: assert property (
    s_col_end_pop ##0 (sub_r == LAST_SUB) |=> sub_r == 4'd0)
    else $error("subaddress did not wrap after the last device");
  AST_LAST_CMD: assert property (
    pop_cmd && !b[`LCR_CONT_BIT] |=> state_r == LCR_ST_DATA)
    else $error("final command did not switch to data");
  AST_ROWS: assert property (
    tick && mux_r == 2'b01 && row_r == 5'd7 |=> row_r == 5'd0)
    else $error("eight-row scan did not wrap");
  AST_SCAN: assert property (
    tick ##1 !tick [*2] |-> ##[1:1000] tick)
    else $error("row scan stalled");
  AST_BLANK: assert property (
    tick && dstat_r == LCR_DS_BLANK |=> col_o == '0)
    else $error("blank status drove a dot");
  AST_ALLON: assert property (
    tick && dstat_r == LCR_DS_ALLON |=> col_o == '1)
    else $error("all-on status left a dot off");
  AST_BANK: assert property (
    pop_cmd && op_bank |=> bank_r == $past(b[1:0]))
    else $error("start bank not taken");
endmodule
`default_nettype wire

// *** tb/lcr_host_model.sv ***
// Byte source standing in for the bus front end and its master.
// Assumes the block's valid/ready byte input; drives on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module lcr_host_model (
  // Clock
  input wire logic clock_i,
  // Byte stream to the block
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_first_o,
  input wire logic rx_ready_i
);
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_first_o = 1'b0;
  end
  // Callers send location commands before data and end commands with top bit 0
  task automatic put(input logic f, input logic [7:0] b, output logic tmo);
    int n;
    n = 0;
    @(negedge clock_i);
    while (rx_ready_i !== 1'b1 && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    // The caller ends the run when ready never came
    tmo = (n >= 2000);
    rx_valid_o = 1'b1;
    rx_first_o = f;
    rx_byte_o = b;
    // Ready is registered, so it is still high at this edge and the byte is taken
    @(posedge clock_i);
    @(negedge clock_i);
    rx_valid_o = 1'b0;
    // Idle lines never keep the last byte, so stale values cannot pass for new ones
    rx_byte_o = ~b;
    rx_first_o = ~f;
  endtask
endmodule
`default_nettype wire

// *** tb/lcr_column_ram_access_tb.sv ***
// Self-checking bench of the column-RAM access block.
// Assumes the host model drives bytes; subaddress pins tied to 0.
`timescale 1ns/1ns
`default_nettype none
module lcr_column_ram_access_tb;
  import lcr_pkg::*;
  logic clock_i, rst_n_i, rx_valid, rx_first, rx_ready, frame_sync;
  logic [7:0] rx_byte;
  logic [39:0] col, ex;
  logic [4:0] row;
  logic [1:0] dstat, mux;
  int num_errors = 0, n_compared = 0, cyc = 0, rmax = 0;
  lcr_column_ram_access lcr_column_ram_access_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .rx_first_i(rx_first),
    .rx_ready_o(rx_ready), .hw_subaddr_i(4'h0), .col_o(col), .row_o(row),
    .frame_sync_o(frame_sync), .disp_status_o(dstat), .mux_sel_o(mux));
  lcr_host_model lcr_host_model_i (.clock_i(clock_i), .rx_valid_o(rx_valid),
    .rx_byte_o(rx_byte), .rx_first_o(rx_first), .rx_ready_i(rx_ready));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 95000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic f, input logic [7:0] b);
    logic tmo;
    lcr_host_model_i.put(f, b, tmo);
    if (tmo) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  // Waits for a fresh scan of row r, so data written before it is visible
  task automatic wait_row(input int r);
    int n;
    n = 0;
    repeat (20) @(negedge clock_i);
    while (row === r[4:0] && n < 40000) begin
      @(negedge clock_i);
      n++;
    end
    while (row !== r[4:0] && n < 40000) begin
      @(negedge clock_i);
      if (row > rmax) rmax = row;
      n++;
    end
    // A scan that never reaches the row is a failure, not a skipped check
    if (n >= 40000) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic t_reset();
    check(dstat, LCR_DS_BLANK);
    check(mux, 2'b00);
  endtask
  task automatic t_status();
    for (int e = 0; e < 4; e++) begin
      put(1'b1, {3'b010, 1'b0, e[1:0], 2'b01});
      repeat (20) @(negedge clock_i);
      check(dstat, e[1:0]);
      check(mux, 2'b01);
    end
  endtask
  task automatic t_char();
    put(1'b1, 8'hc5);
    put(1'b0, 8'he0);
    put(1'b0, 8'hf0);
    put(1'b0, 8'h00);
    for (int c = 0; c < 40; c++) put(1'b0, 8'h01 << (c % 8));
    // Runs into the next device, which is not this one
    put(1'b0, 8'hff);
    for (int c = 0; c < 40; c++) ex[c] = (c % 8 == 3);
    wait_row(0);
    wait_row(3);
    check(col, ex);
    check(frame_sync, 1'b0);
    rmax = 0;
    wait_row(7);
    check(frame_sync, 1'b1);
    // Rows between 7 and 0 show whether the frame really ends after eight rows
    wait_row(0);
    check(frame_sync, 1'b0);
    check(rmax, 7);
    put(1'b1, 8'h4d);
    wait_row(3);
    check(col, ~ex);
    put(1'b1, 8'h49);
    wait_row(3);
    check(col, {40{1'b1}});
  endtask
  task automatic t_wrap();
    put(1'b1, 8'hc5);
    put(1'b0, 8'hef);
    put(1'b0, 8'hf0);
    put(1'b0, 8'h27);
    put(1'b0, 8'hff);
    put(1'b0, 8'h08);
    ex[0] = 1'b1;
    wait_row(3);
    check(col, ex);
  endtask
  task automatic t_full();
    put(1'b1, 8'hc6);
    put(1'b0, 8'he0);
    put(1'b0, 8'hf8);
    put(1'b0, 8'h05);
    for (int i = 0; i < 8; i++) put(1'b0, (i % 2 == i / 4) ? 8'hff : 8'h00);
    wait_row(0);
    check({col[6], col[5]}, 2'b01);
    wait_row(8);
    check({col[6], col[5]}, 2'b10);
    put(1'b1, 8'h7d);
    wait_row(0);
    check({col[6], col[5]}, 2'b10);
    put(1'b1, 8'he0);
    put(1'b0, 8'hf4);
    put(1'b0, 8'h0a);
    for (int i = 0; i < 4; i++) put(1'b0, (i == 0 || i == 3) ? 8'hff : 8'h00);
    wait_row(0);
    check({col[11], col[10]}, 2'b10);
  endtask
  initial begin
    rst_n_i = 1'b0;
    repeat (6) @(negedge clock_i);
    t_reset();
    rst_n_i = 1'b1;
    repeat (6) @(negedge clock_i);
    t_reset();
    t_status();
    t_char();
    t_wrap();
    t_full();
    tally_and_finish();
  end
endmodule
`default_nettype wire
